// [hw/spp_port.sv]
// spp_port: six-bit bidirectional port with pulldowns and pin interrupts
// assumes an APB master on the same clock and synchronous pin inputs
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - output pins drive data latch value
// R2 - read gives latch for outputs, pin for inputs
// R3 - data bits 7 and 6 read zero
// R4 - reset leaves data latch unchanged
// R5 - direction one enables driver, kills pulldown
// R6 - reset clears direction, blocks comparator drive
// R7 - direction bits 7 and 6 read zero
// R8 - direction register fully readable and writable
// R9 - data latch writes always take effect
// R10 - pulldown on needs option, inhibit, direction zero
// R11 - global inhibit option turns all pulldowns off
// R12 - pulldown inhibit write-only, reads undefined
// R13 - reset clears all pulldown inhibit bits
// R14 - upper group bit gates third port upper
// R15 - lower group bit gates third port lower
// R16 - option lets four low pins interrupt
// R17 - port interrupts active high or rising
// R18 - option selects edge-only or edge-and-level
// R19 - pin-level branch sees only dedicated pin
// R20 - rising port pin wakes from stop/wait
// R21 - all requests merge into one external request
module spp_port
    import spp_pkg::*;
#(
    parameter int PINS = 6
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    // port pins
    input  wire spp_pkg::spp_pins_t pins_in,
    output spp_pkg::spp_pins_t      pins_drv,
    // pulldown enables
    input  wire logic [7:0]   third_port_direction_reg,
    output spp_pkg::spp_pulls_t     pulls,
    // comparator drive of the two upper pins
    input  wire logic [1:0]   cmp_out,
    // dedicated interrupt pin and system side
    input  wire logic         irq_pin_n,
    output logic              ext_irq_request,
    output logic              wake_request,
    output logic              branch_pin_level
);
    import spp_pkg::*;

    // elaboration check: the register layout serves six pins only
    if (PINS != SPP_PINS) begin : g_pins_check
        $error("spp_port supports exactly six pins");
    end

    logic [5:0]  first_port_data_reg;
    logic [5:0]  first_port_direction_reg;
    logic [7:0]  first_port_pulldown_inhibit_reg;
    logic [3:0]  one_time_option_register;
    logic [31:0] prdata_next;
    logic        access;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic [5:0]  pin_level;
    logic [5:0]  drive_val;
    logic        req;
    logic        wk;
    logic        global_pulldown_inhibit_option;
    logic        port_interrupt_option;
    logic        level_option;
    logic        cmp_enable;

    // decode of one aligned word
    function automatic logic is_reg(input logic [11:0] a,
                                    input logic [11:0] ofs);
        return a == ofs;
    endfunction

    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign rd     = access && !pwrite;
    assign mapped = is_reg(paddr, SPP_DATA_OFS) ||
                    is_reg(paddr, SPP_DIR_OFS)  ||
                    is_reg(paddr, SPP_PDI_OFS)  ||
                    is_reg(paddr, SPP_OPT_OFS)  ||
                    is_reg(paddr, SPP_STAT_OFS);
    assign pready  = 1'b1; // zero wait states
    assign pslverr = access && !mapped;

    assign global_pulldown_inhibit_option =
        one_time_option_register[SPP_OPT_SWPD_BIT];
    assign port_interrupt_option =
        one_time_option_register[SPP_OPT_PORT_INTERRUPT_OPTION_BIT];
    assign level_option = one_time_option_register[SPP_OPT_LVL_BIT];
    assign cmp_enable   = one_time_option_register[SPP_OPT_CMP_BIT];

    // data latch has no reset term at all
    always_ff @(posedge clock) begin // R4
        if (wr && is_reg(paddr, SPP_DATA_OFS)) begin
            first_port_data_reg <= pwdata[5:0]; // R9
        end
    end

    // direction register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_port_direction_reg <= SPP_DIR_RST; // R6
        end else if (wr && is_reg(paddr, SPP_DIR_OFS)) begin
            first_port_direction_reg <= pwdata[5:0]; // R8
        end
    end

    // write-only pulldown inhibit register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            first_port_pulldown_inhibit_reg <= SPP_PDI_RST; // R13
        end else if (wr && is_reg(paddr, SPP_PDI_OFS)) begin
            first_port_pulldown_inhibit_reg <= pwdata[7:0];
        end
    end

    // option register standing in for the one-time options
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            one_time_option_register <= SPP_OPT_RST; // R6
        end else if (wr && is_reg(paddr, SPP_OPT_OFS)) begin
            one_time_option_register <= pwdata[3:0];
        end
    end

    // pin read value: latch for outputs, pin level for inputs
    assign pin_level = (first_port_direction_reg & first_port_data_reg) |
                       (~first_port_direction_reg & pins_in.pin_in); // R2

    // read mux
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (is_reg(paddr, SPP_DATA_OFS)) begin
            prdata_next = {26'h0, pin_level}; // R3
        end else if (is_reg(paddr, SPP_DIR_OFS)) begin
            prdata_next = {26'h0, first_port_direction_reg}; // R7
        end else if (is_reg(paddr, SPP_PDI_OFS)) begin
            prdata_next = SPP_UNDEF_RD; // R12
        end else if (is_reg(paddr, SPP_OPT_OFS)) begin
            prdata_next = {28'h000_0000, one_time_option_register};
        end else if (is_reg(paddr, SPP_STAT_OFS)) begin
            prdata_next[SPP_STAT_REQ_BIT]  = ext_irq_request;
            prdata_next[SPP_STAT_IRQP_BIT] = irq_pin_n;
        end
    end

    // read data register, loaded at the end of the setup phase
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_next;
        end
    end

    // comparator may replace latch on the two upper pins once enabled
    assign drive_val = {cmp_enable ? cmp_out : first_port_data_reg[5:4],
                        first_port_data_reg[3:0]}; // R6

    // pin drivers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins_drv <= '0;
        end else begin
            pins_drv.pin_in  <= '0;
            pins_drv.pin_out <= drive_val; // R1
            pins_drv.pin_oe  <= first_port_direction_reg; // R5
        end
    end

    // pulldown enables
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pulls <= '0;
        end else begin
            pulls.port_pd <= {6{!global_pulldown_inhibit_option}} &
                ~first_port_pulldown_inhibit_reg[5:0] &
                ~first_port_direction_reg; // R5 R10 R11
            pulls.third_pd[7:4] <= {4{!global_pulldown_inhibit_option &&
                !first_port_pulldown_inhibit_reg[SPP_PDI_HIGH_BIT]}} &
                ~third_port_direction_reg[7:4]; // R14
            pulls.third_pd[3:0] <= {4{!global_pulldown_inhibit_option &&
                !first_port_pulldown_inhibit_reg[SPP_PDI_LOW_BIT]}} &
                ~third_port_direction_reg[3:0]; // R15
        end
    end

    // interrupt detection on the four low pins
    spp_irq_detect #(
        .N(SPP_IRQ_PINS)
    ) u_irq (
        .clock      (clock),
        .rst        (rst),
        .enable     (port_interrupt_option), // R16
        .level_mode (level_option), // R18
        .pins       (pins_in.pin_in[3:0]), // R17
        .irq_pin_n  (irq_pin_n),
        .request    (req),
        .wake       (wk)
    );

    // registered request outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_irq_request  <= 1'b0;
            wake_request     <= 1'b0;
            branch_pin_level <= 1'b1;
        end else begin
            ext_irq_request  <= req; // R21
            wake_request     <= wk; // R20
            branch_pin_level <= irq_pin_n; // R19
        end
    end
endmodule
`default_nettype wire

// [hw/spp_pkg.sv]
// spp_pkg: register map, field layout and shared types of the six-bit port
// assumes a 32-bit APB slave with one register per aligned word
package spp_pkg;
    localparam int          SPP_PINS          = 6;
    localparam int          SPP_IRQ_PINS      = 4;
    // register byte offsets
    localparam logic [11:0] SPP_DATA_OFS      = 12'h000;
    localparam logic [11:0] SPP_DIR_OFS       = 12'h004;
    localparam logic [11:0] SPP_PDI_OFS       = 12'h008;
    localparam logic [11:0] SPP_OPT_OFS       = 12'h00c;
    localparam logic [11:0] SPP_STAT_OFS      = 12'h010;
    // pulldown-inhibit register field positions
    localparam int          SPP_PDI_LOW_BIT   = 6;
    localparam int          SPP_PDI_HIGH_BIT  = 7;
    // option register field positions
    localparam int          SPP_OPT_SWPD_BIT  = 0;
    localparam int          SPP_OPT_PORT_INTERRUPT_OPTION_BIT  = 1;
    localparam int          SPP_OPT_LVL_BIT   = 2;
    localparam int          SPP_OPT_CMP_BIT   = 3;
    // status register field positions
    localparam int          SPP_STAT_REQ_BIT  = 0;
    localparam int          SPP_STAT_IRQP_BIT = 1;
    // reset values
    localparam logic [5:0]  SPP_DIR_RST       = 6'h00;
    localparam logic [7:0]  SPP_PDI_RST       = 8'h00;
    localparam logic [3:0]  SPP_OPT_RST       = 4'h0;
    // value returned for the write-only register
    localparam logic [31:0] SPP_UNDEF_RD      = 32'h0000_0000;

    // pin group of the port: input, output level, output enable
    typedef struct packed {
        logic [SPP_PINS-1:0] pin_in;
        logic [SPP_PINS-1:0] pin_out;
        logic [SPP_PINS-1:0] pin_oe;
    } spp_pins_t;

    // pulldown enables for this port and the third port
    typedef struct packed {
        logic [SPP_PINS-1:0] port_pd;
        logic [7:0]          third_pd;
    } spp_pulls_t;
endpackage

// [hw/spp_irq_detect.sv]
// spp_irq_detect: combined external interrupt request for the port pins
// assumes pins and the dedicated interrupt pin are synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module spp_irq_detect #(
    parameter int N = 4
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // controls
    input  wire logic         enable,
    input  wire logic         level_mode,
    // sources
    input  wire logic [N-1:0] pins,
    input  wire logic         irq_pin_n,
    // result
    output logic              request,
    output logic              wake
);
    logic [N-1:0] pins_reg;
    logic         irq_n_reg;
    logic         rise;
    logic         fall;
    logic         lvl;

    // elaboration check: at least one interrupt pin
    if (N < 1) begin : g_n_check
        $error("spp_irq_detect needs at least one pin");
    end

    // previous samples for edge detection
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins_reg  <= '0;
            irq_n_reg <= 1'b1;
        end else begin
            pins_reg  <= pins;
            irq_n_reg <= irq_pin_n;
        end
    end

    // port pins active high, dedicated pin active low
    assign rise = enable && |(pins & ~pins_reg); // R17
    assign fall = irq_n_reg && !irq_pin_n;
    assign lvl  = level_mode && ((enable && |pins) || !irq_pin_n); // R18
    assign request = rise || fall || lvl; // R16 R21
    assign wake    = rise; // R20
endmodule
`default_nettype wire

// [verif/spp_ext_model.sv]
// spp_ext_model: external circuits hanging on the six port pins
// assumes pins_drv and pulls come straight from the port outputs
`timescale 1ns/1ps
`default_nettype none
module spp_ext_model
    import spp_pkg::*;
(
    // pin side
    input  wire logic                clock,
    input  wire spp_pkg::spp_pins_t  pins_drv,
    input  wire spp_pkg::spp_pulls_t pulls,
    // external source per pin
    input  wire logic [5:0]          ext_val,
    input  wire logic [5:0]          ext_en,
    output spp_pkg::spp_pins_t       pins_in
);
    logic [5:0] flip_reg = 6'h15;
    // a released line with no pulldown wanders every cycle
    always_ff @(posedge clock) flip_reg <= ~flip_reg;
    // wire level: port driver, then circuit, then pulldown
    always_comb begin
        pins_in = '0;
        for (int i = 0; i < 6; i++)
            pins_in.pin_in[i] = pins_drv.pin_oe[i] ? pins_drv.pin_out[i] :
                ext_en[i] ? ext_val[i] :
                pulls.port_pd[i] ? 1'b0 : flip_reg[i];
    end
endmodule
`default_nettype wire

// [verif/spp_port_sva.sv]
// spp_chk: port-level properties of the six-bit port
// assumes it is bound into spp_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module spp_chk
    import spp_pkg::*;
(
    // clock and reset
    input wire logic                clock,
    input wire logic                rst,
    // bus
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pslverr,
    // pins and system side
    input wire spp_pkg::spp_pins_t  pins_in,
    input wire spp_pkg::spp_pins_t  pins_drv,
    input wire spp_pkg::spp_pulls_t pulls,
    input wire logic [7:0]          third_port_direction_reg,
    input wire logic                irq_pin_n,
    input wire logic                wake_request,
    input wire logic                ext_irq_request,
    input wire logic                branch_pin_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_out_no_pull: assert property (
        (pins_drv.pin_oe & pulls.port_pd) == 6'h00)
        else $error("pulldown on while pin drives");
    a_third_pull: assert property (
        (pulls.third_pd & $past(third_port_direction_reg)) == 8'h00)
        else $error("third port pulldown on an output");
    a_top_zero: assert property (psel && !penable && !pwrite &&
        (paddr == SPP_DATA_OFS || paddr == SPP_DIR_OFS)
        |=> prdata[31:6] == 26'h0) else $error("upper read bits set");
    a_pdi_read: assert property (psel && !penable && !pwrite &&
        paddr == SPP_PDI_OFS |=> prdata == SPP_UNDEF_RD)
        else $error("write-only register read value");
    a_rst_dir: assert property ($fell(rst) |-> pins_drv.pin_oe == 6'h00)
        else $error("pin driven after reset");
    a_rst_pull: assert property ($fell(rst) |-> ##1 pulls.port_pd == 6'h3f)
        else $error("pulldowns not on after reset");
    a_branch_pin: assert property (!$past(rst) |->
        branch_pin_level == $past(irq_pin_n))
        else $error("branch level not the interrupt pin");
    a_wake_pulse: assert property (wake_request |->
        |($past(pins_in.pin_in[3:0]) & ~$past(pins_in.pin_in[3:0], 2)))
        else $error("wake without a rising interrupt pin");
    c_wake: cover property (wake_request);
    c_refused: cover property (pslverr);
    c_request: cover property (ext_irq_request);
endmodule
bind spp_port spp_chk chk (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .pins_drv(pins_drv), .pulls(pulls),
    .pins_in(pins_in),
    .third_port_direction_reg(third_port_direction_reg),
    .irq_pin_n(irq_pin_n), .wake_request(wake_request),
    .ext_irq_request(ext_irq_request), .branch_pin_level(branch_pin_level));
`default_nettype wire

// [verif/tb_six_bit_port_with_pulldowns.sv]
// tb_six_bit_port_with_pulldowns: self-checking bench of the six-bit port
// assumes spp_port, spp_ext_model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_six_bit_port_with_pulldowns;
    import spp_pkg::*;
    logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        irq_n = 1, pready, pslverr, ext_irq, wake, brl, seen;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, d, m;
    logic [5:0]  ext_val = 0, ext_en = 6'h3f;
    logic [7:0]  tdir = 0, p, t_exp;
    logic [1:0]  cmp = 0;
    logic [3:0]  o;
    logic [32:0] e_now, q_exp[$];
    spp_pins_t   pin_i, pin_d;
    spp_pulls_t  pulls;
    int          err_total = 0, total_checks = 0, cyc = 0;
    spp_port uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pins_in(pin_i),
        .pins_drv(pin_d), .third_port_direction_reg(tdir), .pulls(pulls),
        .cmp_out(cmp), .irq_pin_n(irq_n), .ext_irq_request(ext_irq),
        .wake_request(wake), .branch_pin_level(brl));
    spp_ext_model ext (.clock(clock), .pins_drv(pin_d), .pulls(pulls),
        .ext_val(ext_val), .ext_en(ext_en), .pins_in(pin_i));
    always #2.5 clock = ~clock;
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    // one apb transfer; a read notes its expected {pslverr, prdata}
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, input logic [32:0] e);
        if (!w) q_exp.push_back(e);
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
        @(negedge clock);
    endtask
    // cycle ceiling
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin err_total++; end_sim(); end
    end
    // read answers against the oldest note
    always @(posedge clock) if (psel && penable && pready && !pwrite) begin
        e_now = q_exp.pop_front();
        `CHK("read", e_now, ({pslverr, prdata}))
    end
    initial begin
        void'($urandom(16));
        d = $urandom();
        m = $urandom();
        @(posedge clock);
        {tdir, cmp, ext_val} <= 16'($urandom());
        repeat (11) @(posedge clock);
        rst <= 1'b0;
        apb(0, SPP_DIR_OFS, 0, 33'h0);
        `CHK("oe", 6'h00, pin_d.pin_oe)
        `CHK("pd", 6'h3f, pulls.port_pd)
        `CHK("tpd", ~tdir, pulls.third_pd)
        apb(1, SPP_DATA_OFS, d, 0);
        apb(0, SPP_DATA_OFS, 0, {27'h0, ext_val});
        apb(1, SPP_DIR_OFS, 32'hffff_ffff, 0);
        apb(0, SPP_DIR_OFS, 0, 33'h3f);
        `CHK("out", d[5:0], pin_d.pin_out)
        `CHK("pdo", 6'h00, pulls.port_pd)
        apb(0, SPP_DATA_OFS, 0, {27'h0, d[5:0]});
        apb(1, SPP_DIR_OFS, m, 0);
        apb(0, SPP_DATA_OFS, 0,
            {27'h0, (d[5:0] & m[5:0]) | (ext_val & ~m[5:0])});
        apb(0, SPP_DIR_OFS, 0, {27'h0, m[5:0]});
        apb(1, SPP_DIR_OFS, 0, 0);
        for (int i = 0; i < 4; i++) begin
            p = 8'($urandom());
            apb(1, SPP_PDI_OFS, {24'h0, p}, 0);
            tick(2);
            t_exp = ~tdir & ~{{4{p[7]}}, {4{p[6]}}};
            `CHK("pdi", ~p[5:0], pulls.port_pd)
            `CHK("tpdi", t_exp, pulls.third_pd)
            apb(0, SPP_PDI_OFS, 0, {1'b0, SPP_UNDEF_RD});
        end
        apb(1, SPP_PDI_OFS, 0, 0);
        // released inputs must settle low through their pulldowns
        @(posedge clock);
        ext_en <= 6'h00;
        apb(0, SPP_DATA_OFS, 0, 33'h0);
        apb(1, SPP_OPT_OFS, 32'h1, 0);
        tick(2);
        `CHK("gpd", 6'h00, pulls.port_pd)
        `CHK("gtpd", 8'h00, pulls.third_pd)
        for (int k = 0; k < 3; k++) begin
            o = (k == 0) ? 4'h0 : (k == 1) ? 4'h2 : 4'h6;
            @(posedge clock);
            ext_val[3:0] <= 4'h0;
            ext_en       <= 6'h3f;
            apb(1, SPP_OPT_OFS, {28'h0, o}, 0);
            tick(3);
            @(posedge clock);
            ext_val[k] <= 1'b1;
            seen = 1'b0;
            repeat (6) begin
                @(negedge clock);
                seen = seen | wake;
            end
            `CHK("wake", o[1], seen)
            `CHK("req", o[2], ext_irq)
        end
        @(posedge clock);
        ext_val[3:0] <= 4'h0;
        irq_n <= 1'b0;
        tick(3);
        `CHK("brl", 1'b0, brl)
        apb(0, SPP_STAT_OFS, 0, 33'h1);
        @(posedge clock);
        irq_n <= 1'b1;
        apb(0, 12'h020, 0, 33'h1_0000_0000);
        apb(1, SPP_DATA_OFS, ~d, 0);
        // comparator drive of the upper pins, then blocked by reset
        apb(1, SPP_DIR_OFS, 32'h3f, 0);
        @(posedge clock);
        cmp <= d[5:4];
        apb(1, SPP_OPT_OFS, 32'h8, 0);
        tick(2);
        `CHK("cmp", ({d[5:4], ~d[3:0]}), pin_d.pin_out)
        @(posedge clock);
        rst <= 1'b1;
        tick(2);
        @(posedge clock);
        rst <= 1'b0;
        apb(1, SPP_DIR_OFS, 32'h3f, 0);
        tick(2);
        `CHK("keep", ~d[5:0], pin_d.pin_out)
        apb(0, SPP_DATA_OFS, 0, {27'h0, ~d[5:0]});
        tick(2);
        end_sim();
    end
endmodule
`default_nettype wire
